// ---- inc/adc_cmp_pkg.sv ----
package adc_cmp_pkg;
    // -------------------------------------------------
    // Register byte offsets
    // -------------------------------------------------
    localparam logic [7:0] OFF_CTRL_FIRST  = 8'h00; // Mode and input select
    localparam logic [7:0] OFF_INT_SECOND  = 8'h04; // Interrupt/skip select
    localparam logic [7:0] OFF_ACC         = 8'h08; // Accumulator image
    localparam logic [7:0] OFF_REG_B       = 8'h0c; // Register B image
    localparam logic [7:0] OFF_OP          = 8'h10; // Instruction strobe
    localparam logic [7:0] OFF_STATUS      = 8'h14; // Flag, busy, skip
    localparam logic [7:0] OFF_RESULT      = 8'h18; // 10-bit result
    localparam logic [7:0] OFF_CMP         = 8'h1c; // Comparator value

    // -------------------------------------------------
    // Field positions
    // -------------------------------------------------
    localparam int MODE_BIT    = 3; // 1 comparator, 0 conversion
    localparam int ST_FLAG_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_SKIP_BIT = 2;

    // -------------------------------------------------
    // Instruction codes written to the strobe register
    // -------------------------------------------------
    localparam logic [2:0] OP_CONVERT_START = 3'h1;
    localparam logic [2:0] OP_LOW_TO_ACC    = 3'h2;
    localparam logic [2:0] OP_SKIP_IF_DONE  = 3'h3;
    localparam logic [2:0] OP_CMP_LOAD      = 3'h4;
    localparam logic [2:0] OP_INT_TAKEN     = 3'h5;

    // -------------------------------------------------
    // Reset values and timing
    // -------------------------------------------------
    localparam logic [3:0] CTRL_RST     = 4'h0;
    localparam logic [3:0] INT_RST      = 4'h0;
    localparam int         MC_CYCLES    = 2;  // Machine cycles before first step
    localparam int         ADC_DIV_DEF  = 6;  // Instruction clock per converter clock
    localparam int         SAR_STEPS    = 10; // Bits of a conversion
    localparam int         CNT_W        = 8;

    typedef enum logic {ST_IDLE, ST_RUN} conv_state_e;
endpackage

// ---- design/adc_comparator_mode_control.sv ----
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// R01 - Start instruction begins single comparator comparison
// R02 - Comparison ends after 2 cycles plus one converter clock
// R03 - Input below comparison value sets done flag
// R04 - Low two result bits go to accumulator top
// R05 - Low two accumulator bits forced to zero
// R06 - Software keeps mode bit still while busy
// R07 - Software clears interrupt bit before leaving comparator
// R08 - Leaving comparator mode may set done flag
// R09 - Software issues skip after mode change
// R10 - Interrupt taken or skip clears done flag
// R11 - Mode bit one comparator, zero conversion
// R12 - Comparator load takes B high, accumulator low
// R13 - Conversion writes 10-bit result when finished
// R14 - Input not below leaves flag unchanged
module adc_comparator_mode_control
    import adc_cmp_pkg::*;
#(
    parameter int ADC_DIV = ADC_DIV_DEF
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Analog front end, digitised input level
    input  wire logic [9:0]  ain_code,
    // Status
    output logic             conversion_done_flag,
    output logic             conv_busy
);
    // -------------------------------------------------
    // Declarations
    // -------------------------------------------------
    localparam logic [CNT_W-1:0] FIRST_CNT = CNT_W'(MC_CYCLES + ADC_DIV - 1);
    localparam logic [CNT_W-1:0] STEP_CNT  = CNT_W'(ADC_DIV - 1);

    logic [9:0]       ain_s1_q, ain_s2_q;      // Two-stage synchroniser
    logic [3:0]       ctrl_q, ctrl_d;          // converter_control_first
    logic [3:0]       intc_q, intc_d;          // interrupt_control_second
    logic [3:0]       acc_q, acc_d;            // Accumulator image
    logic [3:0]       regb_q, regb_d;          // Register B image
    logic [7:0]       cmp_q, cmp_d;            // Comparator value
    logic [9:0]       res_q, res_d;            // Result register
    logic [9:0]       mask_q, mask_d;          // Bit under trial
    logic [CNT_W-1:0] cnt_q, cnt_d;            // Cycles to next step
    logic             flag_q, flag_d;          // conversion_done_flag
    logic             skip_q, skip_d;          // Last skip result
    conv_state_e      state_q, state_d;
    logic [31:0]      rdata_q, rdata_d;
    logic             ready_q, ready_d;
    logic             err_q, err_d;

    logic             acc_w, wr_w;             // Access completes
    logic             mapped_w;
    logic [2:0]       op_w;
    logic             start_w, low_bits_to_acc_op_w, skip_w, load_w, itak_w, mode_fall_w;
    logic             step_w, finish_w, below_w, set_w, clear_w;
    logic [9:0]       trial_w;

    // -------------------------------------------------
    // Input synchroniser
    // -------------------------------------------------
    // Analog code arrives unsynchronised; only the second stage is used
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ain_s1_q <= 10'h000;
            ain_s2_q <= 10'h000;
        end else begin
            ain_s1_q <= ain_code;
            ain_s2_q <= ain_s1_q;
        end
    end

    // -------------------------------------------------
    // Decode
    // -------------------------------------------------
    // Access ends one wait state after the access phase opens
    assign acc_w    = psel && penable && ready_q;
    assign wr_w     = acc_w && pwrite && !err_q;
    assign op_w     = pwdata[2:0];
    assign mapped_w = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
    // Instruction strobes
    assign start_w  = wr_w && paddr == OFF_OP && op_w == OP_CONVERT_START;
    assign low_bits_to_acc_op_w   = wr_w && paddr == OFF_OP && op_w == OP_LOW_TO_ACC;
    assign skip_w   = wr_w && paddr == OFF_OP && op_w == OP_SKIP_IF_DONE;
    assign load_w   = wr_w && paddr == OFF_OP && op_w == OP_CMP_LOAD;
    assign itak_w   = wr_w && paddr == OFF_OP && op_w == OP_INT_TAKEN;
    // Comparator to conversion mode change
    assign mode_fall_w = wr_w && paddr == OFF_CTRL_FIRST && ctrl_q[MODE_BIT]
                         && !pwdata[MODE_BIT];
    // Converter clock tick while running
    assign step_w   = (state_q == ST_RUN) && (cnt_q == '0);
    assign trial_w  = res_q | mask_q;
    // Comparator ends at first step, conversion at last bit
    assign finish_w = step_w && (ctrl_q[MODE_BIT] || mask_q[0]);  // R11
    assign below_w  = ain_s2_q[9:2] < cmp_q;
    // Flag events; set wins over clear
    assign set_w    = (finish_w && (!ctrl_q[MODE_BIT] || below_w)) // R03 R14
                      || mode_fall_w;                              // R08
    assign clear_w  = itak_w || (skip_w && flag_q);               // R10

    // -------------------------------------------------
    // Next state
    // -------------------------------------------------
    always_comb begin
        ctrl_d  = ctrl_q;
        intc_d  = intc_q;
        acc_d   = acc_q;
        regb_d  = regb_q;
        cmp_d   = cmp_q;
        res_d   = res_q;
        mask_d  = mask_q;
        cnt_d   = cnt_q;
        skip_d  = skip_q;
        state_d = state_q;
        // Set beats clear in the same cycle
        flag_d  = set_w ? 1'b1 : (clear_w ? 1'b0 : flag_q); // R10
        // Plain register writes; mode bit assumed stable while busy
        if (wr_w) begin
            case (paddr)
                OFF_CTRL_FIRST: ctrl_d = pwdata[3:0]; // R06
                OFF_INT_SECOND: intc_d = pwdata[3:0]; // R07
                OFF_ACC:        acc_d  = pwdata[3:0];
                OFF_REG_B:      regb_d = pwdata[3:0];
                default: ;
            endcase
        end
        // Low result bits into accumulator top, bottom cleared
        if (low_bits_to_acc_op_w) begin
            acc_d = {res_q[1:0], 2'b00}; // R04 R05
        end
        // Comparator value only writable in comparator mode
        if (load_w && ctrl_q[MODE_BIT]) begin
            cmp_d = {regb_q, acc_q}; // R12
        end
        if (skip_w) begin
            skip_d = flag_q;
        end
        case (state_q)
            ST_IDLE: begin
                // Start ignored while running
                if (start_w) begin
                    state_d = ST_RUN;           // R01
                    cnt_d   = FIRST_CNT;        // R02
                    mask_d  = 10'h200;
                    if (!ctrl_q[MODE_BIT]) begin
                        res_d = 10'h000;
                    end
                end
            end
            ST_RUN: begin
                if (!step_w) begin
                    cnt_d = cnt_q - CNT_W'(1);
                end else if (ctrl_q[MODE_BIT]) begin
                    state_d = ST_IDLE;          // R02
                end else begin
                    // Keep trial bit if not above input
                    if (trial_w <= ain_s2_q) begin
                        res_d = trial_w;        // R13
                    end
                    mask_d = mask_q >> 1;
                    cnt_d  = STEP_CNT;
                    if (mask_q[0]) begin
                        state_d = ST_IDLE;      // R13
                    end
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // -------------------------------------------------
    // APB answer
    // -------------------------------------------------
    // Read data captured with the wait state, unmapped gives error
    always_comb begin
        ready_d = psel && penable && !ready_q;
        // Error flop only ever stands beside pready, so it drives the pin directly
        err_d   = ready_d && !mapped_w;
        rdata_d = rdata_q;
        if (ready_d) begin
            rdata_d = 32'h0000_0000;
            case (paddr)
                OFF_CTRL_FIRST: rdata_d[3:0] = ctrl_q;
                OFF_INT_SECOND: rdata_d[3:0] = intc_q;
                OFF_ACC:        rdata_d[3:0] = acc_q;
                OFF_REG_B:      rdata_d[3:0] = regb_q;
                OFF_STATUS:     rdata_d[2:0] = {skip_q, state_q == ST_RUN, flag_q};
                OFF_RESULT:     rdata_d[9:0] = res_q;
                OFF_CMP:        rdata_d[7:0] = cmp_q;
                default: ;
            endcase
        end
    end

    // -------------------------------------------------
    // Registers
    // -------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= CTRL_RST;
            intc_q  <= INT_RST;
            acc_q   <= 4'h0;
            regb_q  <= 4'h0;
            cmp_q   <= 8'h00;
            res_q   <= 10'h000;
            mask_q  <= 10'h000;
            cnt_q   <= '0;
            flag_q  <= 1'b0;
            skip_q  <= 1'b0;
            state_q <= ST_IDLE;
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            ctrl_q  <= ctrl_d;
            intc_q  <= intc_d;
            acc_q   <= acc_d;
            regb_q  <= regb_d;
            cmp_q   <= cmp_d;
            res_q   <= res_d;
            mask_q  <= mask_d;
            cnt_q   <= cnt_d;
            flag_q  <= flag_d;
            skip_q  <= skip_d;
            state_q <= state_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q   <= err_d;
        end
    end

    assign prdata               = rdata_q;
    assign pready               = ready_q;
    assign pslverr              = err_q;
    assign conversion_done_flag = flag_q;
    assign conv_busy            = (state_q == ST_RUN);

    // -------------------------------------------------
    // Assertions
    // -------------------------------------------------
    start_run_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
        start_w && state_q == ST_IDLE |=> state_q == ST_RUN)
        else $error("start did not launch operation");
    cmp_time_a: assert property (@(posedge pclk) disable iff (!presetn) // R02
        $rose(state_q == ST_RUN) && ctrl_q[MODE_BIT]
        |-> (state_q == ST_RUN) [*8] ##1 state_q == ST_IDLE)
        else $error("comparison length wrong");
    flag_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
        finish_w && ctrl_q[MODE_BIT] && below_w |=> flag_q)
        else $error("flag not set on below");
    low_bits_to_acc_op_move_a: assert property (@(posedge pclk) disable iff (!presetn) // R04
        low_bits_to_acc_op_w |=> acc_q[3:2] == $past(res_q[1:0]))
        else $error("low bits not moved");
    low_bits_to_acc_op_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // R05
        low_bits_to_acc_op_w |=> acc_q[1:0] == 2'b00)
        else $error("accumulator low bits not zero");
    mode_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // R08
        mode_fall_w |=> flag_q && !ctrl_q[MODE_BIT])
        else $error("mode change flag missing");
    skip_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
        skip_w && flag_q && !set_w |=> !flag_q && skip_q)
        else $error("skip did not clear flag");
    cmp_load_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
        load_w && ctrl_q[MODE_BIT] |=> cmp_q == {$past(regb_q), $past(acc_q)})
        else $error("comparator load wrong");
    conv_done_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
        finish_w && !ctrl_q[MODE_BIT] |=> flag_q && state_q == ST_IDLE
        && res_q == (($past(trial_w) <= $past(ain_s2_q)) ? $past(trial_w) : $past(res_q)))
        else $error("conversion end wrong");
    flag_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // R14
        finish_w && ctrl_q[MODE_BIT] && !below_w && !clear_w && !mode_fall_w
        |=> flag_q == $past(flag_q))
        else $error("flag changed on not below");
endmodule

// ---- tb/cpu_core_model.sv ----
`timescale 1ns/1ps
// Behavioural CPU side: issues APB transfers for register and op accesses
module cpu_core_model (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // Idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // -------------------------------------------------
    // One transfer, held until pready seen at an edge
    // -------------------------------------------------
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Sampled values before this edge's updates land
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines must not look like held data
        pwdata <= ~d;
        paddr <= ~a;
    endtask
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
    import adc_cmp_pkg::*;
    // -------------------------------------------------
    // Signals
    // -------------------------------------------------
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, flag, busy;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0]  ain_code = 10'h000;
    logic        err;
    logic [31:0] seed = 32'd56170;
    logic        expf = 1'b0;
    logic [7:0]  cmpv;
    logic [9:0]  expr;
    int          err_total = 0, n_compared = 0, cyc = 0, n;

    always #20 pclk = ~pclk;

    cpu_core_model u_cpu_core_model (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    adc_comparator_mode_control #(.ADC_DIV(6)) u_adc_comparator_mode_control (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ain_code(ain_code),
        .conversion_done_flag(flag), .conv_busy(busy));

    // -------------------------------------------------
    // Helpers
    // -------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Successive approximation: trial bit kept if trial <= input
    function automatic logic [9:0] sar_exp(input logic [9:0] v);
        logic [9:0] r;
        r = 10'h000;
        for (int b = 9; b >= 0; b--) begin
            if ((r | (10'h001 << b)) <= v) r = r | (10'h001 << b);
        end
        return r;
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_cpu_core_model.xfer(1'b1, a, d, rd, err);
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        u_cpu_core_model.xfer(1'b0, a, 32'h0, rd, err);
        chk(what, exp, rd);
    endtask
    // Start, then count edges until busy drops
    task automatic start_and_time();
        wr(OFF_OP, {29'h0, OP_CONVERT_START});
        #1;
        n = 0;
        while (busy === 1'b1 && n < 300) begin
            @(posedge pclk);
            #1;
            n++;
        end
    endtask
    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Hang guard, well above the sequence length
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end

    // -------------------------------------------------
    // Main sequence
    // -------------------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("status", OFF_STATUS, 32'h0);
        rdchk("ctrl", OFF_CTRL_FIRST, 32'h0);
        u_cpu_core_model.xfer(1'b0, 8'h20, 32'h0, rd, err);
        chk("slverr", 32'h1, {31'h0, err});
        wr(OFF_CTRL_FIRST, 32'h8);
        rdchk("ctrl", OFF_CTRL_FIRST, 32'h8);
        for (int i = 0; i < 8; i++) begin
            cmpv = 8'(rnd());
            cmpv[4] = 1'b1;
            wr(OFF_REG_B, {28'h0, cmpv[7:4]});
            wr(OFF_ACC, {28'h0, cmpv[3:0]});
            wr(OFF_OP, {29'h0, OP_CMP_LOAD});
            rdchk("cmp", OFF_CMP, {24'h0, cmpv});
            // Boundary cases: just below, then equal
            ain_code <= (i == 0) ? {cmpv - 8'h01, 2'b11} :
                        (i == 1) ? {cmpv, 2'b00} : 10'(rnd());
            start_and_time();
            chk("cmp time", 2 + 6, n);
            expf = expf | (ain_code[9:2] < cmpv);
            chk("flag", {31'h0, expf}, {31'h0, flag});
            if (i[0]) begin
                wr(OFF_OP, {29'h0, OP_SKIP_IF_DONE});
                rdchk("skip", OFF_STATUS, {29'h0, expf, 2'b00});
                expf = 1'b0;
            end else if (i == 4) begin
                wr(OFF_OP, {29'h0, OP_INT_TAKEN});
                expf = 1'b0;
                // Let the completion edge's update land before looking
                #1;
                chk("int clr", 32'h0, {31'h0, flag});
            end
        end
        wr(OFF_INT_SECOND, 32'h0);
        wr(OFF_CTRL_FIRST, 32'h0);
        #1;
        chk("mode flag", 32'h1, {31'h0, flag});
        wr(OFF_OP, {29'h0, OP_SKIP_IF_DONE});
        #1;
        chk("flag clr", 32'h0, {31'h0, flag});
        // Load refused outside comparator mode: new operands must not land
        wr(OFF_ACC, {28'h0, ~cmpv[3:0]});
        wr(OFF_OP, {29'h0, OP_CMP_LOAD});
        rdchk("cmp keep", OFF_CMP, {24'h0, cmpv});
        for (int i = 0; i < 4; i++) begin
            ain_code <= (i == 0) ? 10'h3ff : (i == 1) ? 10'h000 : 10'(rnd());
            start_and_time();
            expr = sar_exp(ain_code);
            chk("conv time", 2 + 10 * 6, n);
            chk("conv flag", 32'h1, {31'h0, flag});
            rdchk("result", OFF_RESULT, {22'h0, expr});
            wr(OFF_ACC, 32'hf);
            wr(OFF_OP, {29'h0, OP_LOW_TO_ACC});
            rdchk("acc", OFF_ACC, {28'h0, expr[1:0], 2'b00});
            wr(OFF_OP, {29'h0, OP_SKIP_IF_DONE});
        end
        report_and_stop();
    end
endmodule
